// ### src/event_flag.sv
// Single sticky event flag with write-one-to-clear; set wins over clear.
// Assumes set and clear are single-cycle qualified strobes in the clk domain.
`timescale 1ns/1ns
module event_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clear,
  output logic flag
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

  a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    set |=> flag)
    else $error("flag not set after event");
  a_clear_works: assert property (@(posedge clk) disable iff (!rst_n)
    clear && !set |=> !flag)
    else $error("flag not cleared by write one");
  a_hold_state: assert property (@(posedge clk) disable iff (!rst_n)
    !set && !clear |=> flag == $past(flag))
    else $error("flag changed without cause");
endmodule // event_flag

// ### src/pci_function_status_register.sv
// Status register of the flash media function plus the command bits it depends on.
// Assumes configuration writes/reads arrive as one-cycle requests on the PCI clock.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Function
// - Writing one to a clearable status bit clears it
// - Writing zero to any status bit leaves it unchanged
// - Bit 15 sets on address or data parity error
// - Bit 14 sets when system error enabled and error driven
// - Bit 13 sets when own master cycle ends in master abort
// - Bit 12 sets when own master cycle gets target abort
// - Bit 11 sets when acting target ends cycle with target abort
// - Bits 10:9 read constant 01b, medium select timing
// - Bit 8 sets on PERR while master with parity response enabled
// - Bit 7 always reads zero, no back-to-back
// - Bit 6 always reads zero, no user features
// - Bit 5 always reads zero, 33 MHz maximum
// - Bit 4 always reads one, capability chain present
// - INTx asserted only while pending set and mask clear
// - Mask does not alter pending bit
// - Pending set only for enabled valid interrupt conditions
// - Bits 2:0 read zero, writes ignored
// - Command bit 10 blocks INTx, resets to zero
// - Command bit 8 enables system error driver after address parity
module pci_function_status_register
  import status_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire cfg_req_s cfg_req,
  input wire logic cfg_valid,
  output logic [15:0] cfg_rdata,
  output logic cfg_ack,
  input wire bus_events_s bus_events,
  input wire logic [7:0] irq_sources,
  input wire logic [7:0] irq_enables,
  output logic intx_n,
  output logic serr_request,
  output logic [15:0] status_value,
  output logic [15:0] command_bits
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic hits(input cfg_req_s r, input logic [7:0] off);
    return r.addr == off;
  endfunction

  logic status_wr;
  logic command_wr;
  logic [15:0] lane_mask;
  logic [15:0] clear_bits;
  assign lane_mask = {{8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};
  assign status_wr = cfg_valid && cfg_req.wr && hits(cfg_req, STATUS_OFFSET);
  assign command_wr = cfg_valid && cfg_req.wr && hits(cfg_req, COMMAND_OFFSET);
  // Only ones on enabled lanes of clearable positions clear anything
  assign clear_bits = status_wr ? (cfg_req.wdata & lane_mask & CLEAR_MASK) : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Command bits joined here
  logic parity_response_enable;
  logic system_error_enable;
  logic irq_mask;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      parity_response_enable <= 1'b0;
      system_error_enable <= 1'b0;
      irq_mask <= 1'b0;
    end else if (command_wr) begin
      if (cfg_req.be[0]) begin
        parity_response_enable <= cfg_req.wdata[PARITY_RESPONSE_ENABLE_BIT];
      end
      if (cfg_req.be[1]) begin
        system_error_enable <= cfg_req.wdata[SERR_EN_BIT];
        irq_mask <= cfg_req.wdata[IRQ_MASK_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags
  logic [5:0] set_ev;
  logic [5:0] flags;
  localparam int FLAG_POS [6] = '{PAR_BIT, SYSERR_BIT, RECEIVED_MASTER_ABORT_BIT, TABORT_RX_BIT,
                                   TABORT_TX_BIT, DATA_PARITY_REPORTED_BIT};

  assign set_ev[0] = bus_events.addr_parity_err || bus_events.data_parity_err;
  assign set_ev[1] = system_error_enable && bus_events.serr_driven;
  assign set_ev[2] = bus_events.master_abort;
  assign set_ev[3] = bus_events.target_abort_rx;
  assign set_ev[4] = bus_events.target_abort_tx;
  assign set_ev[5] = bus_events.perr_seen && bus_events.master_phase
                     && parity_response_enable;

  generate
    for (genvar i = 0; i < 6; i++) begin : g_flag
      event_flag u_flag (
        .clk(clk),
        .rst_n(rst_n),
        .set(set_ev[i]),
        .clear(clear_bits[FLAG_POS[i]]),
        .flag(flags[i])
      );
    end
  endgenerate

  // System error driver only fires from address parity when enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serr_request <= 1'b0;
    end else begin
      serr_request <= system_error_enable && bus_events.addr_parity_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pending tracks enabled conditions only; mask does not enter
  logic irq_pending;
  logic irq_wanted;
  logic next_irq_mask;
  assign irq_wanted = |(irq_sources & irq_enables);
  // A mask write acts on INTx at the edge it lands, so the pin never lags the mask
  assign next_irq_mask = (command_wr && cfg_req.be[1]) ? cfg_req.wdata[IRQ_MASK_BIT]
                                                       : irq_mask;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pending <= 1'b0;
    end else begin
      irq_pending <= irq_wanted;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intx_n <= 1'b1;
    end else begin
      intx_n <= !(irq_wanted && !next_irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read image
  always_comb begin
    status_value = 16'h0000;
    status_value[PAR_BIT] = flags[0];
    status_value[SYSERR_BIT] = flags[1];
    status_value[RECEIVED_MASTER_ABORT_BIT] = flags[2];
    status_value[TABORT_RX_BIT] = flags[3];
    status_value[TABORT_TX_BIT] = flags[4];
    status_value[DATA_PARITY_REPORTED_BIT] = flags[5];
    status_value[10:9] = SELECT_TIMING;
    status_value[4] = STATUS_RESET[4];
    status_value[IRQ_PEND_BIT] = irq_pending;
  end

  always_comb begin
    command_bits = 16'h0000;
    command_bits[PARITY_RESPONSE_ENABLE_BIT] = parity_response_enable;
    command_bits[SERR_EN_BIT] = system_error_enable;
    command_bits[IRQ_MASK_BIT] = irq_mask;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 16'h0000;
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_valid;
      if (cfg_valid && !cfg_req.wr) begin
        if (hits(cfg_req, STATUS_OFFSET)) begin
          cfg_rdata <= status_value & lane_mask;
        end else if (hits(cfg_req, COMMAND_OFFSET)) begin
          cfg_rdata <= command_bits & lane_mask;
        end else begin
          cfg_rdata <= 16'h0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Steps that the properties below are built from
  sequence s_enabled_irq;
    irq_wanted;
  endsequence

  sequence s_mask_write;
    command_wr && cfg_req.be[1];
  endsequence

  // A status write with no event in flight, so only the written ones move flags
  sequence s_quiet_write;
    status_wr && set_ev == 6'h00;
  endsequence

  sequence s_abort_on_clear;
    bus_events.master_abort && clear_bits[RECEIVED_MASTER_ABORT_BIT];
  endsequence

  sequence s_status_read;
    cfg_valid && !cfg_req.wr && hits(cfg_req, STATUS_OFFSET);
  endsequence

  sequence s_command_read;
    cfg_valid && !cfg_req.wr && hits(cfg_req, COMMAND_OFFSET);
  endsequence

  sequence s_other_read;
    cfg_valid && !cfg_req.wr && !hits(cfg_req, STATUS_OFFSET)
    && !hits(cfg_req, COMMAND_OFFSET);
  endsequence

  // Interrupt pin and pending bit
  a_intx_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !intx_n |-> irq_pending && !irq_mask)
    else $error("INTx asserted while masked or idle");
  a_intx_raise: assert property (@(posedge clk) disable iff (!rst_n)
    irq_wanted && !next_irq_mask |=> !intx_n)
    else $error("INTx missed an unmasked condition");
  a_mask_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    irq_mask |-> intx_n)
    else $error("INTx asserted while masked");
  a_mask_keeps_pending: assert property (@(posedge clk) disable iff (!rst_n)
    s_mask_write |=> irq_pending == $past(irq_wanted))
    else $error("mask write disturbed pending");
  a_pending_follows: assert property (@(posedge clk) disable iff (!rst_n)
    s_enabled_irq |=> irq_pending)
    else $error("pending missed an enabled condition");
  a_pending_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !irq_wanted |=> !irq_pending)
    else $error("pending set without enabled condition");
  a_mask_reset: assert property (@(posedge clk)
    !rst_n |-> !irq_mask)
    else $error("mask not zero in reset");

  // Event flags at the register image
  a_parity_flag: assert property (@(posedge clk) disable iff (!rst_n)
    bus_events.addr_parity_err |=> status_value[PAR_BIT])
    else $error("parity flag not set");
  a_data_parity_flag: assert property (@(posedge clk) disable iff (!rst_n)
    bus_events.data_parity_err |=> status_value[PAR_BIT])
    else $error("parity flag missed a data parity error");
  a_serr_flag: assert property (@(posedge clk) disable iff (!rst_n)
    !system_error_enable && !status_value[SYSERR_BIT] && !command_wr
    |=> !status_value[SYSERR_BIT])
    else $error("system error flag set while disabled");
  a_syserr_set: assert property (@(posedge clk) disable iff (!rst_n)
    system_error_enable && bus_events.serr_driven |=> status_value[SYSERR_BIT])
    else $error("system error flag not set");
  a_received_master_abort_flag: assert property (@(posedge clk) disable iff (!rst_n)
    bus_events.master_abort |=> status_value[RECEIVED_MASTER_ABORT_BIT])
    else $error("master abort flag not set");
  a_tabort_rx_flag: assert property (@(posedge clk) disable iff (!rst_n)
    bus_events.target_abort_rx |=> status_value[TABORT_RX_BIT])
    else $error("received target abort flag not set");
  a_tabort_tx_flag: assert property (@(posedge clk) disable iff (!rst_n)
    bus_events.target_abort_tx |=> status_value[TABORT_TX_BIT])
    else $error("signaled target abort flag not set");
  a_data_parity_reported_gate: assert property (@(posedge clk) disable iff (!rst_n)
    bus_events.perr_seen && bus_events.master_phase && parity_response_enable
    |=> status_value[DATA_PARITY_REPORTED_BIT])
    else $error("data parity flag not set");
  a_data_parity_reported_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !(bus_events.perr_seen && bus_events.master_phase && parity_response_enable)
    && !status_value[DATA_PARITY_REPORTED_BIT] |=> !status_value[DATA_PARITY_REPORTED_BIT])
    else $error("data parity flag set without all conditions");
  a_event_wins: assert property (@(posedge clk) disable iff (!rst_n)
    s_abort_on_clear |=> status_value[RECEIVED_MASTER_ABORT_BIT])
    else $error("event lost to a same cycle clear");

  // Per flag at the image: a write of one clears it unless its own event fires too
  generate
    for (genvar k = 0; k < 6; k++) begin : g_flag_check
      a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
        clear_bits[FLAG_POS[k]] && !set_ev[k] |=> !status_value[FLAG_POS[k]])
        else $error("status flag not cleared by write one");
      a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
        set_ev[k] |=> status_value[FLAG_POS[k]])
        else $error("status flag missed its event");
    end
  endgenerate

  // Clearing writes
  a_clear_takes: assert property (@(posedge clk) disable iff (!rst_n)
    s_quiet_write |=> (status_value & $past(clear_bits)) == 16'h0000)
    else $error("written one left a flag set");
  a_zero_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    s_quiet_write |=> (status_value & CLEAR_MASK & ~$past(clear_bits))
      == ($past(status_value) & CLEAR_MASK & ~$past(clear_bits)))
    else $error("flag moved on a zero write");

  // Hardwired bits
  a_fixed_bits: assert property (@(posedge clk) disable iff (!rst_n)
    status_value[10:0] ==? {2'b01, 1'b?, 4'b0001, 1'b?, 3'b000})
    else $error("hardwired status bits wrong");
  a_timing_code: assert property (@(posedge clk) disable iff (!rst_n)
    status_value[10:9] == SELECT_TIMING)
    else $error("select timing code wrong");
  a_speed_bits: assert property (@(posedge clk) disable iff (!rst_n)
    status_value[7:5] == 3'b000)
    else $error("capability bits 7 to 5 not zero");
  a_chain_bit: assert property (@(posedge clk) disable iff (!rst_n)
    status_value[4])
    else $error("capability chain bit not set");
  a_low_zeros: assert property (@(posedge clk) disable iff (!rst_n)
    status_value[2:0] == 3'b000 && cfg_rdata[2:0] == 3'b000)
    else $error("reserved low bits not zero");
  a_command_bits_only: assert property (@(posedge clk) disable iff (!rst_n)
    (command_bits & ~COMMAND_MASK) == 16'h0000)
    else $error("command image shows a bit outside its mask");

  // Register bus and system error driver
  a_ack_follows: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_valid |=> cfg_ack)
    else $error("request not acknowledged");
  a_ack_single: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_valid |=> !cfg_ack)
    else $error("acknowledge without request");
  a_read_image: assert property (@(posedge clk) disable iff (!rst_n)
    s_status_read |=> cfg_rdata == $past(status_value & lane_mask))
    else $error("status read data wrong");
  a_command_read: assert property (@(posedge clk) disable iff (!rst_n)
    s_command_read |=> cfg_rdata == $past(command_bits & lane_mask))
    else $error("command read data wrong");
  a_other_read: assert property (@(posedge clk) disable iff (!rst_n)
    s_other_read |=> cfg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_valid || cfg_req.wr |=> $stable(cfg_rdata))
    else $error("read data moved without a read");
  a_cmd_low_lane: assert property (@(posedge clk) disable iff (!rst_n)
    command_wr && cfg_req.be[0]
    |=> parity_response_enable == $past(cfg_req.wdata[PARITY_RESPONSE_ENABLE_BIT]))
    else $error("parity response enable not written");
  a_serr_enable_lands: assert property (@(posedge clk) disable iff (!rst_n)
    command_wr && cfg_req.be[1]
    |=> system_error_enable == $past(cfg_req.wdata[SERR_EN_BIT]))
    else $error("system error enable not written");
  a_serr_drive: assert property (@(posedge clk) disable iff (!rst_n)
    serr_request |-> $past(system_error_enable) && $past(bus_events.addr_parity_err))
    else $error("system error driven without cause");
  a_serr_fires: assert property (@(posedge clk) disable iff (!rst_n)
    system_error_enable && bus_events.addr_parity_err |=> serr_request)
    else $error("system error not driven after address parity");
endmodule // pci_function_status_register

// ### src/status_pkg.sv
// Package for the function status register: offsets, field positions, reset values.
// Assumes a 16-bit configuration data path with byte enables, PCI clock domain only.
package status_pkg;
  localparam logic [7:0] STATUS_OFFSET = 8'h06;
  localparam logic [7:0] COMMAND_OFFSET = 8'h04;
  localparam logic [15:0] STATUS_RESET = 16'h0210;
  localparam int PAR_BIT = 15;
  localparam int SYSERR_BIT = 14;
  localparam int RECEIVED_MASTER_ABORT_BIT = 13;
  localparam int TABORT_RX_BIT = 12;
  localparam int TABORT_TX_BIT = 11;
  localparam int DATA_PARITY_REPORTED_BIT = 8;
  localparam int IRQ_PEND_BIT = 3;
  localparam int PARITY_RESPONSE_ENABLE_BIT = 6;
  localparam int SERR_EN_BIT = 8;
  localparam int IRQ_MASK_BIT = 10;
  localparam logic [1:0] SELECT_TIMING = 2'h1;
  // Mask of the clearable event flags
  localparam logic [15:0] CLEAR_MASK = 16'hf900;
  localparam logic [15:0] COMMAND_MASK = 16'h0540;

  typedef struct packed {
    logic addr_parity_err;
    logic data_parity_err;
    logic serr_driven;
    logic master_abort;
    logic target_abort_rx;
    logic target_abort_tx;
    logic perr_seen;
    logic master_phase;
  } bus_events_s;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } cfg_req_s;
endpackage

// ### test/cfg_host.sv
// Host bridge model that issues configuration reads and writes to the status register.
// Assumes callers enter access at a falling clock edge; inputs change only off the rising edge.
`timescale 1ns/1ns
module cfg_host
  import status_pkg::*;
(
  input wire logic clk,
  input wire logic cfg_ack,
  input wire logic [15:0] cfg_rdata,
  output cfg_req_s cfg_req,
  output logic cfg_valid,
  output logic timed_out
);
  initial begin
    cfg_req = '0;
    cfg_valid = 1'b0;
    timed_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle request strobe, then a bounded wait for the acknowledge pulse
  task automatic access(input logic wr, input logic [7:0] addr, input logic [1:0] be,
                        input logic [15:0] wdata, output logic [15:0] rdata);
    int n;
    cfg_req = '{wr: wr, addr: addr, be: be, wdata: wdata};
    cfg_valid = 1'b1;
    @(negedge clk);
    cfg_valid = 1'b0;
    // Released lines show the inverse so stale values never look valid
    cfg_req = ~cfg_req;
    for (n = 0; n < 4 && cfg_ack !== 1'b1; n++) @(negedge clk);
    if (cfg_ack !== 1'b1) timed_out = 1'b1;
    rdata = cfg_rdata;
    // Gap cycle keeps a back-to-back caller from driving twice in one step
    @(negedge clk);
  endtask
endmodule // cfg_host

// ### test/tb.sv
// Self-checking bench for the function status register.
// Assumes the host model in cfg_host.sv; all inputs change at the falling edge.
`timescale 1ns/1ns
module tb
  import status_pkg::*;
;
  logic clk, rst_n, valid, ack, intx_n, serr_request, timed_out;
  cfg_req_s req;
  bus_events_s ev;
  logic [7:0] src, en;
  logic [15:0] rdata, status_value, command_bits, rv;
  int n_fail = 0;
  int total_checks = 0;

  pci_function_status_register dut (.clk(clk), .rst_n(rst_n), .cfg_req(req),
    .cfg_valid(valid), .cfg_rdata(rdata), .cfg_ack(ack), .bus_events(ev),
    .irq_sources(src), .irq_enables(en), .intx_n(intx_n), .serr_request(serr_request),
    .status_value(status_value), .command_bits(command_bits));
  cfg_host host (.clk(clk), .cfg_ack(ack), .cfg_rdata(rdata), .cfg_req(req),
    .cfg_valid(valid), .timed_out(timed_out));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] be,
                     input logic [15:0] d);
    host.access(w, a, be, d, rv);
    if (timed_out) begin
      n_fail++;
      results();
    end
  endtask

  // One bus event with a given command setting, then the zero-write and clearing sequence
  task automatic ev_case(input logic [15:0] cmd, input bus_events_s e, input logic [15:0] exp);
    acc(1'b1, COMMAND_OFFSET, 2'h3, cmd);
    ev = e;
    @(negedge clk);
    ev = '0;
    chk({15'h0, serr_request}, {15'h0, e.addr_parity_err & cmd[SERR_EN_BIT]});
    chk(status_value, STATUS_RESET | exp);
    acc(1'b1, STATUS_OFFSET, 2'h3, ~exp);
    acc(1'b0, STATUS_OFFSET, 2'h3, 16'h0000);
    chk(rv, STATUS_RESET | exp);
    acc(1'b1, STATUS_OFFSET, 2'h3, 16'hffff);
    acc(1'b0, STATUS_OFFSET, 2'h3, 16'h0000);
    chk(rv, STATUS_RESET);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ev = '0;
    src = 8'h00;
    en = 8'h00;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    acc(1'b0, STATUS_OFFSET, 2'h3, 16'h0000);
    chk(rv, 16'h0210);
    acc(1'b0, COMMAND_OFFSET, 2'h3, 16'h0000);
    chk(rv, 16'h0000);
    acc(1'b1, COMMAND_OFFSET, 2'h1, 16'hffff);
    acc(1'b0, COMMAND_OFFSET, 2'h3, 16'h0000);
    chk(rv, 16'h0040);
    chk(command_bits, 16'h0040);
    chk({15'h0, ack}, 16'h0000);
    acc(1'b0, 8'h08, 2'h3, 16'h0000);
    chk(rv, 16'h0000);
    ev_case(16'h0140, 8'h80, 16'h8000);
    ev_case(16'h0000, 8'h80, 16'h8000);
    ev_case(16'h0140, 8'h40, 16'h8000);
    ev_case(16'h0140, 8'h20, 16'h4000);
    ev_case(16'h0000, 8'h20, 16'h0000);
    ev_case(16'h0140, 8'h10, 16'h2000);
    ev_case(16'h0140, 8'h08, 16'h1000);
    ev_case(16'h0140, 8'h04, 16'h0800);
    ev_case(16'h0140, 8'h03, 16'h0100);
    ev_case(16'h0000, 8'h03, 16'h0000);
    ev_case(16'h0140, 8'h02, 16'h0000);
    // Event lands on the same edge as the clearing write
    ev = 8'h10;
    fork
      acc(1'b1, STATUS_OFFSET, 2'h3, 16'hffff);
      begin
        @(negedge clk);
        ev = '0;
      end
    join
    acc(1'b0, STATUS_OFFSET, 2'h3, 16'h0000);
    chk(rv, STATUS_RESET | 16'h2000);
    acc(1'b1, STATUS_OFFSET, 2'h3, 16'hffff);
    acc(1'b1, COMMAND_OFFSET, 2'h3, 16'h0000);
    src = 8'h01;
    repeat (2) @(negedge clk);
    chk(status_value, STATUS_RESET);
    chk({15'h0, intx_n}, 16'h0001);
    en = 8'h01;
    repeat (2) @(negedge clk);
    chk(status_value, STATUS_RESET | 16'h0008);
    chk({15'h0, intx_n}, 16'h0000);
    acc(1'b1, COMMAND_OFFSET, 2'h3, 16'h0400);
    chk({15'h0, intx_n}, 16'h0001);
    chk(status_value, STATUS_RESET | 16'h0008);
    acc(1'b1, COMMAND_OFFSET, 2'h3, 16'h0000);
    chk({15'h0, intx_n}, 16'h0000);
    src = 8'h00;
    repeat (2) @(negedge clk);
    chk({15'h0, intx_n}, 16'h0001);
    chk(status_value, STATUS_RESET);
    // Byte lanes on reads, then a flag and the mask must fall back under a mid-run reset
    ev = 8'h04;
    @(negedge clk);
    ev = '0;
    acc(1'b0, STATUS_OFFSET, 2'h2, 16'h0000);
    chk(rv, 16'h0a00);
    acc(1'b0, STATUS_OFFSET, 2'h1, 16'h0000);
    chk(rv, 16'h0010);
    acc(1'b1, COMMAND_OFFSET, 2'h3, 16'h0540);
    chk(command_bits, 16'h0540);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({15'h0, intx_n}, 16'h0001);
    rst_n = 1'b1;
    acc(1'b0, STATUS_OFFSET, 2'h3, 16'h0000);
    chk(rv, STATUS_RESET);
    chk(command_bits, 16'h0000);
    results();
  end
endmodule // tb
